// ===== logic/pfm_fault_monitor.sv
/*
 * fault monitor and interrupt logic of a multi-rail power device: deglitched
 * monitors, sticky and live status, mask, shutdown selection, device state and
 * the open-drain interrupt.
 * assumes comparator inputs synchronous to clk_i, a sequencer that performs the
 * power-off sequence on request, and a classic wishbone master.
 */
`timescale 1ns/1ns

module pfm_fault_monitor
  import pfm_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic               wb_we_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  // monitor comparators
  input  wire logic [NSD-1:0]     sd_uv_i,
  input  wire logic [NSD-1:0]     sd_ov_i,
  input  wire logic [NSD-1:0]     sd_en_i,
  input  wire logic [NLDO-1:0]    ldo_power_good_i,
  input  wire logic [NLDO-1:0]    ldo_en_i,
  input  wire logic               high_current_i,
  input  wire logic               droop_below_i,
  input  wire logic               refin_below_fall_i,
  input  wire logic               refin_above_rise_i,
  input  wire logic               otw_i,
  input  wire logic               ots_i,
  input  wire logic               analog_supply_lockout_i,
  // sequencer
  input  wire logic               power_on_i,
  input  wire logic               sd2_softstart_done_i,
  input  wire logic               sd2_powerdown_i,
  input  wire logic               sd2_on_i,
  input  wire logic               poweroff_done_i,
  output logic                    rails_run_o,
  output logic                    poweroff_req_o,
  output logic                    fault_off_o,
  output logic [NRSTOUT-1:0]      reset_out_n_o,
  output logic                    term_ref_on_o,
  // analog settings
  output logic [1:0]              droop_thr_o,
  output logic [3:0]              otw_thr_o,
  output logic [3:0]              high_current_limit_setting_o,
  // interrupt pin, open drain
  output logic                    irq_n_o,
  output logic                    irq_oe_n_o
);

  // ==========================================================================
  // registers
  logic [NSRC-1:0]   sticky_r, sticky_nxt;
  logic [NSRC-1:0]   mask_r;
  logic [NSRC-1:0]   shutsel_r;
  pfm_ctrl_t         ctrl_r;
  logic [7:0]        deg_r [NSRC];
  pfm_state_t        state_r, state_nxt;
  logic              otw_q_r;
  logic [8:0]        tick_cnt_r;
  logic              ack_r;
  logic [31:0]       rdat_r;
  logic              irq_oe_n_r;
  logic [NRSTOUT-1:0] reset_out_n_r;
  logic              term_ref_on_r;

  // ==========================================================================
  // bus decode
  wire               bus_req    = wb_cyc_i & wb_stb_i & ~ack_r;
  wire               bus_wr     = bus_req & wb_we_i;
  wire [31:0]        wmask      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0]        wbits      = wb_dat_i & wmask;
  wire               hit_sticky = (wb_adr_i == ADR_STICKY);
  wire               hit_live   = (wb_adr_i == ADR_LIVE);
  wire               hit_mask   = (wb_adr_i == ADR_MASK);
  wire               hit_shut   = (wb_adr_i == ADR_SHUTSEL);
  wire               hit_ctrl   = (wb_adr_i == ADR_CTRL);
  wire               hit_state  = (wb_adr_i == ADR_STATE);
  wire [4:0]         deg_idx    = wb_adr_i[6:2];
  wire               hit_deg    = wb_adr_i[7] & (wb_adr_i[1:0] == 2'b00)
                                  & (deg_idx < 5'(NSRC));

  // ==========================================================================
  // deglitch tick and filters
  wire               tick = (tick_cnt_r == TICK_LAST);
  logic [NSRC-1:0]   raw;
  logic [NSRC-1:0]   filt;

  wire               refin_window = sd2_softstart_done_i & ~sd2_powerdown_i;

  // enable gating, linear power good ungated
  assign raw[IDX_SDUV +: NSD]   = sd_uv_i & sd_en_i;
  assign raw[IDX_SDOV +: NSD]   = sd_ov_i & sd_en_i;
  assign raw[IDX_LDOUV +: NLDO] = ~ldo_power_good_i;
  assign raw[IDX_HC]            = high_current_i;
  assign raw[IDX_DROOP]         = droop_below_i & ctrl_r.droop_en;
  assign raw[IDX_REFIN]         = refin_below_fall_i & refin_window;
  assign raw[IDX_OTW]           = otw_i;
  assign raw[IDX_OTS]           = ots_i;

  for (genvar g = 0; g < NSRC; g++) begin : g_deg
    pfm_deglitch u_deg (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tick_i  (tick),
      .raw_i   (raw[g]),
      .limit_i (deg_r[g]),
      .filt_o  (filt[g])
    );
  end

  // ==========================================================================
  // live and sticky status
  // live view, linear bits shown as power good
  wire [NSRC-1:0] live = filt ^ {{(NSRC-IDX_LDOUV-NLDO){1'b0}}, {NLDO{1'b1}},
                                 {IDX_LDOUV{1'b0}}};
  wire            monitoring = (state_r == ST_ACTIVE);
  logic [NSRC-1:0] set_lvl;
  logic [NSRC-1:0] clr_ok;
  // configurable sources, droop and temperature shutdown always fatal
  // warning bit sits in neither shutdown mask
  wire [NSRC-1:0] shut_eff = (shutsel_r & SHUT_CFG_MASK) | SHUT_FORCED;

  always_comb begin
    set_lvl = filt;
    // linear undervoltage latches only while enabled
    set_lvl[IDX_LDOUV +: NLDO] = filt[IDX_LDOUV +: NLDO] & ldo_en_i;
    // warning latches on a rising live edge
    set_lvl[IDX_OTW] = filt[IDX_OTW] & ~otw_q_r;
    if (!monitoring) begin
      set_lvl = ZERO_SRC;
    end
    // level source relatches in any state while live stays high
    set_lvl[IDX_OTS] = filt[IDX_OTS];
    clr_ok = ~ZERO_SRC;
    if (shut_eff[IDX_REFIN]) begin
      clr_ok[IDX_REFIN] = (state_r != ST_PWROFF);
    end else begin
      clr_ok[IDX_REFIN] = refin_above_rise_i;
    end
  end

  wire [NSRC-1:0] w1c = (bus_wr & hit_sticky) ? wbits[NSRC-1:0] : ZERO_SRC;

  // write one to clear; a set in the same cycle wins
  assign sticky_nxt = set_lvl | (sticky_r & ~(w1c & clr_ok));

  // ==========================================================================
  // shutdown decision
  // a latching fault selected for shutdown trips the sequence
  wire            shut_trip = |(set_lvl & shut_eff);
  wire            irq_pend = |(sticky_r & ~mask_r);

  // ==========================================================================
  // device state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: begin
        state_nxt = ST_STANDBY;
      end
      ST_STANDBY: begin
        // wait indefinitely for the supply to clear the droop level
        if (power_on_i && !(ctrl_r.droop_en && droop_below_i)) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (shut_trip) begin
          state_nxt = ST_PWROFF;
        end else if (!power_on_i) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_PWROFF: begin
        if (poweroff_done_i) begin
          state_nxt = ST_FAULTOFF;
        end
      end
      ST_FAULTOFF: begin
        // restart needs the power-on request to drop first
        if (!power_on_i) begin
          state_nxt = ST_STANDBY;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
    if (analog_supply_lockout_i) begin
      state_nxt = ST_RESET;
    end
  end

  // ==========================================================================
  // read mux
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h0000_0000;
    if (hit_sticky) begin
      rmux[NSRC-1:0] = sticky_r;
    end else if (hit_live) begin
      rmux[NSRC-1:0] = live;
    end else if (hit_mask) begin
      rmux[NSRC-1:0] = mask_r;
    end else if (hit_shut) begin
      rmux[NSRC-1:0] = shut_eff;
    end else if (hit_ctrl) begin
      rmux[CTRL_W-1:0] = ctrl_r;
    end else if (hit_state) begin
      rmux[2:0] = state_r;
    end else if (hit_deg) begin
      rmux[7:0] = deg_r[deg_idx];
    end
  end

  // a reserved threshold code leaves the field unchanged
  wire        thr_legal = (wbits[2:1] != 2'b11) && wb_sel_i[0];
  pfm_ctrl_t  ctrl_wr;

  always_comb begin
    ctrl_wr = pfm_ctrl_t'((ctrl_r & ~wmask[CTRL_W-1:0]) | wbits[CTRL_W-1:0]);
    if (!thr_legal) begin
      ctrl_wr.droop_thr = ctrl_r.droop_thr;
    end
  end

  // ==========================================================================
  // bus-side registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r      <= 1'b0;
      rdat_r     <= 32'h0000_0000;
      tick_cnt_r <= 9'h000;
    end else begin
      ack_r      <= bus_req;
      rdat_r     <= rmux;
      tick_cnt_r <= tick ? 9'h000 : tick_cnt_r + 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r    <= MASK_RST;
      shutsel_r <= SHUT_RST;
      ctrl_r    <= CTRL_RST;
    end else if (bus_wr) begin
      if (hit_mask) begin
        mask_r <= (mask_r & ~wmask[NSRC-1:0]) | wbits[NSRC-1:0];
      end
      if (hit_shut) begin
        shutsel_r <= (shutsel_r & ~wmask[NSRC-1:0]) | wbits[NSRC-1:0];
      end
      if (hit_ctrl) begin
        ctrl_r <= ctrl_wr;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NSRC; i++) begin
      if (rst_i) begin
        deg_r[i] <= (i == IDX_HC || i == IDX_DROOP) ? DEG_FAST : DEG_SLOW;
      end else if (bus_wr && hit_deg && deg_idx == 5'(i) && wb_sel_i[0]) begin
        deg_r[i] <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================================
  // status, state and pin registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_r      <= ZERO_SRC;
      otw_q_r       <= 1'b0;
      state_r       <= ST_RESET;
      irq_oe_n_r    <= 1'b1;
      reset_out_n_r <= '0;
      term_ref_on_r <= 1'b0;
    end else begin
      sticky_r      <= sticky_nxt;
      otw_q_r       <= filt[IDX_OTW];
      state_r       <= state_nxt;
      // pull the line low while anything unmasked is pending
      irq_oe_n_r    <= ~irq_pend;
      // every reset output held asserted outside normal operation
      reset_out_n_r <= (state_nxt == ST_ACTIVE) ? '1 : '0;
      term_ref_on_r <= ctrl_r.term_ref_enable & sd2_on_i;
    end
  end

  // ==========================================================================
  // outputs
  assign wb_ack_o       = ack_r;
  assign wb_dat_o       = rdat_r;
  assign irq_n_o        = 1'b0;
  assign irq_oe_n_o     = irq_oe_n_r;
  assign reset_out_n_o  = reset_out_n_r;
  assign term_ref_on_o  = term_ref_on_r;
  assign poweroff_req_o = (state_r == ST_PWROFF);
  assign rails_run_o    = (state_r == ST_ACTIVE);
  assign fault_off_o    = (state_r == ST_FAULTOFF);
  assign droop_thr_o    = ctrl_r.droop_thr;
  assign otw_thr_o      = ctrl_r.otw_thr;
  // threshold to the current comparator, no shutdown path for this source
  assign high_current_limit_setting_o = ctrl_r.hc_limit;

endmodule : pfm_fault_monitor

// ===== logic/pfm_pkg.sv
/*
 * shared constants and types of the fault monitor: source indices, register map,
 * reset values, deglitch timing and the device state codes.
 * assumes a 50 MHz clock and a 32-bit classic wishbone register bus.
 */
package pfm_pkg;

  // ==========================================================================
  // fault sources
  localparam int NSRC      = 20;
  localparam int IDX_SDUV  = 0;   // six step-down undervoltage monitors
  localparam int IDX_SDOV  = 6;   // six step-down overvoltage monitors
  localparam int IDX_LDOUV = 12;  // three linear regulator undervoltage monitors
  localparam int IDX_HC    = 15;
  localparam int IDX_DROOP = 16;
  localparam int IDX_REFIN = 17;
  localparam int IDX_OTW   = 18;
  localparam int IDX_OTS   = 19;
  localparam int NSD       = 6;
  localparam int NLDO      = 3;
  localparam int NRSTOUT   = 2;

  // sources whose shutdown response software may choose, and those always fatal
  localparam logic [NSRC-1:0] SHUT_CFG_MASK = 20'h27FFF;
  localparam logic [NSRC-1:0] SHUT_FORCED   = 20'h90000;
  localparam logic [NSRC-1:0] SHUT_RST      = 20'h27FFF;
  localparam logic [NSRC-1:0] MASK_RST      = 20'h00000;
  localparam logic [NSRC-1:0] ZERO_SRC      = 20'h00000;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] ADR_STICKY   = 8'h00;
  localparam logic [7:0] ADR_LIVE     = 8'h04;
  localparam logic [7:0] ADR_MASK     = 8'h08;
  localparam logic [7:0] ADR_SHUTSEL  = 8'h0C;
  localparam logic [7:0] ADR_CTRL     = 8'h10;
  localparam logic [7:0] ADR_STATE    = 8'h14;
  localparam logic [7:0] ADR_DEG_BASE = 8'h80;  // one word per source, 0x80..0xCC

  // ==========================================================================
  // deglitch timing: counts are in ticks of 10 us
  localparam int TICK_NS  = 10000;
  localparam int CLK_NS   = 20;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [8:0] TICK_LAST = 9'(TICK_CYC - 1);
  localparam logic [7:0] DEG_SLOW  = 8'h64;   // 1 ms
  localparam logic [7:0] DEG_FAST  = 8'h0A;   // 0.1 ms

  // ==========================================================================
  // control register
  typedef enum logic [1:0] {
    DROOP_THR_5V   = 2'b00,
    DROOP_THR_LION = 2'b01,
    DROOP_THR_3V   = 2'b10
  } pfm_droop_thr_t;

  typedef struct packed {
    logic [3:0]     hc_limit;
    logic [3:0]     otw_thr;
    logic           term_ref_enable;
    pfm_droop_thr_t droop_thr;
    logic           droop_en;
  } pfm_ctrl_t;

  localparam int CTRL_W = 12;
  localparam pfm_ctrl_t CTRL_RST = '{hc_limit: 4'h8, otw_thr: 4'h8, term_ref_enable: 1'b1,
                                     droop_thr: DROOP_THR_LION, droop_en: 1'b0};

  // ==========================================================================
  // device states
  typedef enum logic [2:0] {
    ST_RESET    = 3'b000,
    ST_STANDBY  = 3'b001,
    ST_ACTIVE   = 3'b010,
    ST_PWROFF   = 3'b011,
    ST_FAULTOFF = 3'b100
  } pfm_state_t;

endpackage : pfm_pkg

// ===== logic/pfm_deglitch.sv
/*
 * one deglitch filter: the output follows the raw input only after the input
 * has held its new level for the programmed number of ticks.
 * assumes raw is synchronous to clk and tick is a one-cycle pulse.
 */
`timescale 1ns/1ns
module pfm_deglitch
  import pfm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       raw_i,
  input  wire logic [7:0] limit_i,
  output logic            filt_o
);

  logic [7:0] cnt_r;
  logic       filt_r;
  wire        differs = raw_i ^ filt_r;
  wire        reached = (cnt_r >= limit_i);

  // ==========================================================================
  // counter restarts whenever the input returns, so a glitch never accumulates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 8'h00;
      filt_r <= 1'b0;
    end else if (!differs) begin
      cnt_r <= 8'h00;
    end else if (reached) begin
      cnt_r  <= 8'h00;
      filt_r <= raw_i;
    end else if (tick_i) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign filt_o = filt_r;

endmodule : pfm_deglitch

// ===== testbench/pfm_props.sv
/* port assertions of the fault monitor.
   bound into pfm_fault_monitor; sees its ports only. */
`timescale 1ns/1ns
module pfm_props
  import pfm_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire logic               irq_n_o,
  input wire logic               irq_oe_n_o,
  input wire logic [NRSTOUT-1:0] reset_out_n_o,
  input wire logic               rails_run_o,
  input wire logic               poweroff_req_o,
  input wire logic               poweroff_done_i,
  input wire logic               fault_off_o,
  input wire logic               analog_supply_lockout_i,
  input wire logic               sd2_on_i,
  input wire logic               term_ref_on_o,
  input wire logic               power_on_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====================
  // bus and pin
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  irq_drive_a: assert property (irq_n_o == 1'b0)
    else $error("interrupt pin would drive high");
  irq_rst_a: assert property ($past(rst_i) |-> irq_oe_n_o)
    else $error("interrupt active right after reset");
  // ====================
  // state and sequencing
  rst_out_a: assert property (&reset_out_n_o |-> rails_run_o || $past(rails_run_o))
    else $error("reset outputs released outside active");
  off_seq_a: assert property (poweroff_req_o && poweroff_done_i && !analog_supply_lockout_i
    |=> fault_off_o)
    else $error("no fault-off after power-off done");
  lockout_a: assert property (analog_supply_lockout_i
    |=> !rails_run_o && !fault_off_o && !poweroff_req_o)
    else $error("supply lockout did not force reset state");
  term_ref_a: assert property (term_ref_on_o |-> $past(sd2_on_i))
    else $error("termination reference on without step-down two");
  act_entry_a: assert property ($rose(rails_run_o) |-> $past(power_on_i))
    else $error("active entered without power-on request");
  cover property (poweroff_req_o);
  cover property (!irq_oe_n_o);
  cover property (fault_off_o);
endmodule : pfm_props

bind pfm_fault_monitor pfm_props props_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .irq_n_o, .irq_oe_n_o, .reset_out_n_o, .rails_run_o, .poweroff_req_o, .poweroff_done_i,
  .fault_off_o, .analog_supply_lockout_i, .sd2_on_i, .term_ref_on_o, .power_on_i);

// ===== testbench/pfm_host_model.sv
/* host processor model: classic wishbone master and pulled-up interrupt line.
   assumes one clock shared with the monitor. */
`timescale 1ns/1ns
module pfm_host_model
  import pfm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i,
  input  wire logic        irq_n_i,
  input  wire logic        irq_oe_n_i,
  output logic [7:0]       wb_adr_o,
  output logic [31:0]      wb_dat_o,
  output logic [3:0]       wb_sel_o,
  output logic             wb_we_o,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             irq_line_o
);
  // ====================
  // interrupt pin
  // open drain, pull-up
  assign irq_line_o = irq_oe_n_i ? 1'b1 : irq_n_i;
  initial {wb_adr_o, wb_dat_o, wb_sel_o, wb_we_o, wb_cyc_o, wb_stb_o} = '0;
  // ====================
  // bus cycles
  // request held until ack, released one cycle at least
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, w};
    {wb_adr_o, wb_dat_o, wb_sel_o} <= {a, d, 4'hF};
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    r = wb_dat_i;
    {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'b000;
  endtask : xfer
  // write one to clear, releases the line
  task clr(input logic [31:0] m);
    logic [31:0] r;
    xfer(1'b1, ADR_STICKY, m, r);
  endtask : clr
endmodule : pfm_host_model

// ===== testbench/pfm_fault_monitor_tb_top.sv
/* self-checking bench of the fault monitor.
   host model drives the bus; the bench drives comparator and sequencer inputs. */
`timescale 1ns/1ns
module pfm_fault_monitor_tb_top
  import pfm_pkg::*;
;
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq_line;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [3:0]  wb_sel_i, otw_thr_o, high_current_limit_setting_o;
  logic [5:0]  sd_uv_i, sd_ov_i, sd_en_i;
  logic [2:0]  ldo_power_good_i, ldo_en_i;
  logic [1:0]  reset_out_n_o, droop_thr_o;
  logic        high_current_i, droop_below_i, refin_below_fall_i, refin_above_rise_i;
  logic        otw_i, ots_i, analog_supply_lockout_i, power_on_i, sd2_softstart_done_i;
  logic        sd2_powerdown_i, sd2_on_i, poweroff_done_i, rails_run_o, poweroff_req_o;
  logic        fault_off_o, term_ref_on_o, irq_n_o, irq_oe_n_o;
  int          n_mismatch = 0;
  int          n_compared = 0;

  pfm_fault_monitor dut_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .sd_uv_i, .sd_ov_i, .sd_en_i,
    .ldo_power_good_i, .ldo_en_i, .high_current_i, .droop_below_i, .refin_below_fall_i,
    .refin_above_rise_i, .otw_i, .ots_i, .analog_supply_lockout_i, .power_on_i,
    .sd2_softstart_done_i, .sd2_powerdown_i, .sd2_on_i, .poweroff_done_i, .rails_run_o,
    .poweroff_req_o, .fault_off_o, .reset_out_n_o, .term_ref_on_o, .droop_thr_o,
    .otw_thr_o, .high_current_limit_setting_o, .irq_n_o, .irq_oe_n_o);

  pfm_host_model host_u (.clk_i, .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o),
    .irq_n_i(irq_n_o), .irq_oe_n_i(irq_oe_n_o), .wb_adr_o(wb_adr_i), .wb_dat_o(wb_dat_i),
    .wb_sel_o(wb_sel_i), .wb_we_o(wb_we_i), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
    .irq_line_o(irq_line));

  // ====================
  // helpers
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, '0, q);
    chk(q, e);
  endtask : rdc
  // long enough for a zero-count filter plus tick jitter
  task settle;
    repeat (1100) @(posedge clk_i);
  endtask : settle

  // ====================
  // scenarios
  task t_regs;
    rdc(ADR_MASK, 32'h0);
    rdc(ADR_SHUTSEL, 32'hB7FFF);
    rdc(ADR_CTRL, 32'h88A);
    rdc(ADR_STATE, 32'h1);
    rdc(ADR_DEG_BASE, 32'h64);
    rdc(ADR_DEG_BASE + 8'h3C, 32'h0A);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(ADR_CTRL, 32'h888 | 32'(k << 1));
      repeat (2) @(posedge clk_i);
      chk(32'(droop_thr_o), (k < 3) ? 32'(k) : 32'h2);
    end
    for (int i = 0; i < NSRC; i++) wr(ADR_DEG_BASE + 8'(4 * i), '0);
    rdc(ADR_DEG_BASE + 8'h4C, 32'h0);
    @(posedge clk_i) power_on_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdc(ADR_STATE, 32'h2);
    chk(32'(reset_out_n_o), 32'h3);
    chk(32'(term_ref_on_o), 32'h1);
    $display("done t_regs");
  endtask : t_regs

  task t_hc;
    @(posedge clk_i) high_current_i <= 1'b1;
    settle;
    rdc(ADR_LIVE, 32'hF000);
    rdc(ADR_STICKY, 32'h8000);
    chk(32'(irq_line), 32'h0);
    wr(ADR_MASK, 32'h8000);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_line), 32'h1);
    host_u.clr(32'h8000);
    rdc(ADR_STICKY, 32'h8000);
    @(posedge clk_i) high_current_i <= 1'b0;
    settle;
    rdc(ADR_LIVE, 32'h7000);
    host_u.clr(32'h8000);
    rdc(ADR_STICKY, 32'h0);
    wr(ADR_MASK, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_line), 32'h1);
    $display("done t_hc");
  endtask : t_hc

  task t_temp;
    @(posedge clk_i) otw_i <= 1'b1;
    settle;
    rdc(ADR_STICKY, 32'h40000);
    host_u.clr(32'h40000);
    rdc(ADR_STICKY, 32'h0);
    @(posedge clk_i) otw_i <= 1'b0;
    settle;
    @(posedge clk_i) otw_i <= 1'b1;
    settle;
    rdc(ADR_STICKY, 32'h40000);
    rdc(ADR_STATE, 32'h2);
    @(posedge clk_i) otw_i <= 1'b0;
    settle;
    host_u.clr(32'h40000);
    $display("done t_temp");
  endtask : t_temp

  task t_shut;
    @(posedge clk_i) sd_en_i <= 6'h3F;
    wr(ADR_SHUTSEL, 32'hB7FFE);
    rdc(ADR_SHUTSEL, 32'hB7FFE);
    @(posedge clk_i) sd_uv_i <= 6'h01;
    settle;
    rdc(ADR_STICKY, 32'h1);
    rdc(ADR_STATE, 32'h2);
    @(posedge clk_i) sd_uv_i <= 6'h00;
    settle;
    host_u.clr(32'h1);
    @(posedge clk_i) ots_i <= 1'b1;
    settle;
    rdc(ADR_STATE, 32'h3);
    chk(32'(reset_out_n_o), 32'h0);
    host_u.clr(32'h80000);
    rdc(ADR_STICKY, 32'h80000);
    @(posedge clk_i) poweroff_done_i <= 1'b1;
    @(posedge clk_i) poweroff_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdc(ADR_STATE, 32'h4);
    @(posedge clk_i) ots_i <= 1'b0;
    power_on_i <= 1'b0;
    settle;
    host_u.clr(32'hFFFFF);
    rdc(ADR_STATE, 32'h1);
    $display("done t_shut");
  endtask : t_shut

  task t_refin;
    wr(ADR_SHUTSEL, 32'h97FFE);
    @(posedge clk_i) power_on_i <= 1'b1;
    refin_below_fall_i <= 1'b1;
    refin_above_rise_i <= 1'b0;
    settle;
    rdc(ADR_LIVE, 32'h7000);
    @(posedge clk_i) sd2_softstart_done_i <= 1'b1;
    settle;
    rdc(ADR_STICKY, 32'h20000);
    rdc(ADR_STATE, 32'h2);
    @(posedge clk_i) refin_below_fall_i <= 1'b0;
    settle;
    host_u.clr(32'h20000);
    rdc(ADR_STICKY, 32'h20000);
    @(posedge clk_i) refin_above_rise_i <= 1'b1;
    host_u.clr(32'h20000);
    rdc(ADR_STICKY, 32'h0);
    wr(ADR_SHUTSEL, 32'hB7FFE);
    @(posedge clk_i) refin_below_fall_i <= 1'b1;
    settle;
    rdc(ADR_STATE, 32'h3);
    @(posedge clk_i) refin_below_fall_i <= 1'b0;
    sd2_on_i <= 1'b0;
    settle;
    chk(32'(term_ref_on_o), 32'h0);
    host_u.clr(32'h20000);
    rdc(ADR_STICKY, 32'h20000);
    @(posedge clk_i) poweroff_done_i <= 1'b1;
    @(posedge clk_i) poweroff_done_i <= 1'b0;
    host_u.clr(32'h20000);
    rdc(ADR_STICKY, 32'h0);
    @(posedge clk_i) power_on_i <= 1'b0;
    sd2_on_i <= 1'b1;
    sd2_softstart_done_i <= 1'b0;
    $display("done t_refin");
  endtask : t_refin

  task t_droop;
    wr(ADR_CTRL, 32'h88B);
    @(posedge clk_i) droop_below_i <= 1'b1;
    power_on_i <= 1'b1;
    settle;
    rdc(ADR_STATE, 32'h1);
    @(posedge clk_i) power_on_i <= 1'b0;
    droop_below_i <= 1'b0;
    settle;
    @(posedge clk_i) power_on_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdc(ADR_STATE, 32'h2);
    @(posedge clk_i) droop_below_i <= 1'b1;
    settle;
    rdc(ADR_STICKY, 32'h10000);
    rdc(ADR_STATE, 32'h3);
    @(posedge clk_i) analog_supply_lockout_i <= 1'b1;
    rdc(ADR_STATE, 32'h0);
    $display("done t_droop");
  endtask : t_droop

  // ====================
  // run control
  task report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    rst_i = 1'b1;
    {sd_uv_i, sd_ov_i, sd_en_i, ldo_en_i} = '0;
    {high_current_i, droop_below_i, refin_below_fall_i, otw_i, ots_i} = '0;
    {analog_supply_lockout_i, power_on_i, sd2_softstart_done_i} = '0;
    {sd2_powerdown_i, poweroff_done_i} = '0;
    {ldo_power_good_i, refin_above_rise_i, sd2_on_i} = '1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_hc;
    t_temp;
    t_shut;
    t_refin;
    t_droop;
    report_and_stop;
  end
endmodule : pfm_fault_monitor_tb_top
